// file: hdl/pfc_protection_supervisor.v
// Protection supervisor for a digital boost PFC controller
`timescale 1ns/1ps
`include "pfc_defs.vh"
module pfc_protection_supervisor #(
   parameter BROWN_CYC = `BROWN_MS * `MS_CYC,
   parameter OVL_CYC = `OVL_MS * `MS_CYC,
   parameter OPP_OFF_CYC = `OPP_OFF_MS * `MS_CYC,
   parameter SEVERE_CYC = `SEVERE_CYC
) (
   input wire REF_CLK,
   input wire ARST_N,
   input wire [11:0] OUTPUT_FEEDBACK_INPUT,
   input wire [11:0] LINE_SENSE_INPUT,
   input wire SAMPLE_VALID,
   input wire VALLEY_DETECT_INPUT,
   input wire SWITCH_REQUEST,
   input wire CURRENT_LIMIT_TRIP,
   input wire SEVERE_CLAMP_TRIP,
   input wire THERMAL_HOT,
   output wire SWITCH_DRIVE_OUTPUT,
   output reg VALLEY_PULSE,
   output reg signed [12:0] REGULATION_ERROR,
   output wire BROWNOUT,
   output wire STANDBY,
   output reg OVERVOLTAGE_TRIP,
   output wire OVERCURRENT_TRIP,
   output wire OVERPOWER_TRIP,
   output reg SENSE_FAULT,
   output wire STARTUP_MODE,
   output wire THERMAL_SHUTDOWN
);
   // Brownout states
   localparam BO_RUN = 2'd0;
   localparam BO_LOWWAIT = 2'd1;
   localparam BO_DOWN = 2'd2;
   localparam BO_HIGHWAIT = 2'd3;

   reg rs1_q;
   reg rs2_q;
   wire rst_n;
   wire zc;
   wire cl_trip;
   wire sv_trip;
   wire hot;
   reg [11:0] fb_q;
   reg [11:0] line_q;
   reg [11:0] peak_q;
   reg [11:0] peak_run_q;
   reg [19:0] peak_age_q;
   reg [1:0] bo_q;
   reg [1:0] bo_d;
   reg [31:0] bo_cnt_q;
   reg [3:0] zq_cnt_q;
   reg zq_armed_q;
   reg drive_q;
   reg [4:0] leb_cnt_q;
   reg ocp_q;
   reg [31:0] sev_cnt_q;
   reg start_q;
   reg [31:0] ovl_cnt_q;
   reg [31:0] opp_cnt_q;
   reg opp_q;
   reg [15:0] sense_cnt_q;
   wire inhibit;
   wire sev_hold;
   wire ovl_open;
   wire ovl_keep;
   wire ovl_clear;
   wire ovl_run;

   // Reset release through two flops
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   assign rst_n = rs2_q;

   // Asynchronous pins
   pin_sync u_zc (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .pin(VALLEY_DETECT_INPUT),
      .level(zc)
   );
   pin_sync u_cl (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .pin(CURRENT_LIMIT_TRIP),
      .level(cl_trip)
   );
   pin_sync u_sv (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .pin(SEVERE_CLAMP_TRIP),
      .level(sv_trip)
   );
   pin_sync u_th (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .pin(THERMAL_HOT),
      .level(hot)
   );

   // Over-temperature: sensor supplies its own 9 C hysteresis
   assign THERMAL_SHUTDOWN = hot;

   // Sample capture, regulation error against fixed reference
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         fb_q <= 12'h000;
         line_q <= 12'h000;
         REGULATION_ERROR <= 13'sh0000;
      end else if (SAMPLE_VALID) begin
         fb_q <= OUTPUT_FEEDBACK_INPUT;
         line_q <= LINE_SENSE_INPUT;
         // Compensation is done downstream in the digital loop
         REGULATION_ERROR <= $signed({1'b0, `REF_CODE}) -
                             $signed({1'b0, OUTPUT_FEEDBACK_INPUT});
      end
   end

   // Line peak over a window longer than a half cycle
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         peak_q <= 12'h000;
         peak_run_q <= 12'h000;
         peak_age_q <= 20'h00000;
      end else begin
         peak_age_q <= peak_age_q + 20'h00001;
         if (peak_age_q == 20'hfffff) begin
            peak_q <= peak_run_q;
            peak_run_q <= 12'h000;
         end else if (SAMPLE_VALID) begin
            if (LINE_SENSE_INPUT > peak_run_q) begin
               peak_run_q <= LINE_SENSE_INPUT;
            end
            // Fast attack: a fresh peak counts before the window closes
            if (LINE_SENSE_INPUT > peak_q) begin
               peak_q <= LINE_SENSE_INPUT;
            end
         end
      end
   end

   // Brownout with entry timer on the line peak and exit timer on the line sample
   always @* begin
      bo_d = bo_q;
      case (bo_q)
         BO_RUN: begin
            if (peak_q < `LINE_LOW_CODE) begin
               bo_d = BO_LOWWAIT;
            end
         end
         BO_LOWWAIT: begin
            if (peak_q >= `LINE_LOW_CODE) begin
               bo_d = BO_RUN;
            end else if (bo_cnt_q >= BROWN_CYC) begin
               bo_d = BO_DOWN;
            end
         end
         BO_DOWN: begin
            if (line_q > `LINE_HIGH_CODE) begin
               bo_d = BO_HIGHWAIT;
            end
         end
         BO_HIGHWAIT: begin
            if (line_q <= `LINE_HIGH_CODE) begin
               bo_d = BO_DOWN;
            end else if (bo_cnt_q >= BROWN_CYC) begin
               bo_d = BO_RUN;
            end
         end
         default: begin
            bo_d = BO_RUN;
         end
      endcase
   end

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bo_q <= BO_RUN;
         bo_cnt_q <= 32'h00000000;
      end else begin
         bo_q <= bo_d;
         if (bo_d != bo_q) begin
            bo_cnt_q <= 32'h00000000;
         end else begin
            bo_cnt_q <= bo_cnt_q + 32'h00000001;
         end
      end
   end
   assign BROWNOUT = bo_q[1];
   assign STANDBY = bo_q[1];

   // Valley qualification: falling edge counts only after a long high
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         zq_cnt_q <= 4'h0;
         zq_armed_q <= 1'b0;
         VALLEY_PULSE <= 1'b0;
      end else begin
         VALLEY_PULSE <= 1'b0;
         if (zc) begin
            if (zq_cnt_q >= `QUAL_CYC - 1) begin
               zq_armed_q <= 1'b1;
            end else begin
               zq_cnt_q <= zq_cnt_q + 4'h1;
            end
         end else begin
            zq_cnt_q <= 4'h0;
            zq_armed_q <= 1'b0;
            VALLEY_PULSE <= zq_armed_q;
         end
      end
   end

   // Overvoltage with hysteresis
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         OVERVOLTAGE_TRIP <= 1'b0;
      end else if (SAMPLE_VALID) begin
         if (OUTPUT_FEEDBACK_INPUT > `OVP_CODE) begin
            OVERVOLTAGE_TRIP <= 1'b1;
         end else if (OUTPUT_FEEDBACK_INPUT < `OVP_CODE - `OVP_HYS_CODE) begin
            OVERVOLTAGE_TRIP <= 1'b0;
         end
      end
   end

   // Gate on-time: starts on a valley while requested; ends on limit
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         drive_q <= 1'b0;
         leb_cnt_q <= 5'h00;
         ocp_q <= 1'b0;
      end else begin
         ocp_q <= 1'b0;
         if (!drive_q) begin
            leb_cnt_q <= 5'h00;
            // Controller may skip valleys by holding its request low
            if (VALLEY_PULSE && SWITCH_REQUEST && !inhibit) begin
               drive_q <= 1'b1;
            end
         end else begin
            if (leb_cnt_q < `LEB_CYC) begin
               leb_cnt_q <= leb_cnt_q + 5'h01;
            end
            if (inhibit || !SWITCH_REQUEST) begin
               drive_q <= 1'b0;
            end else if (leb_cnt_q >= `LEB_CYC && cl_trip) begin
               drive_q <= 1'b0;
               ocp_q <= 1'b1;
            end
         end
      end
   end
   assign OVERCURRENT_TRIP = ocp_q | sev_hold;

   // Severe clamp restart hold-off
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sev_cnt_q <= 32'h00000000;
      end else if (sv_trip) begin
         sev_cnt_q <= SEVERE_CYC;
      end else if (sev_cnt_q != 32'h00000000) begin
         sev_cnt_q <= sev_cnt_q - 32'h00000001;
      end
   end
   assign sev_hold = sev_cnt_q != 32'h00000000;

   // Startup mode from output level, with hysteresis
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         start_q <= 1'b1;
      end else if (SAMPLE_VALID) begin
         if (OUTPUT_FEEDBACK_INPUT < `START_CODE) begin
            start_q <= 1'b1;
         end else if (OUTPUT_FEEDBACK_INPUT >= `REF_CODE) begin
            start_q <= 1'b0;
         end
      end
   end
   assign STARTUP_MODE = start_q;

   // Overload watch: startup re-entered repeatedly counts as overload too
   // A zero code means an idle converter, not an overload
   assign ovl_open = start_q && ovl_cnt_q == 32'h00000000 && fb_q > 12'h000 &&
                     fb_q < `START_CODE;
   // Watch stays open while startup has not regained the reference
   assign ovl_keep = start_q && fb_q < `REF_CODE && ovl_cnt_q != 32'h00000000;
   // Light request while regulated means load cleared
   assign ovl_clear = !start_q && ovl_cnt_q != 32'h00000000 && !SWITCH_REQUEST;
   // Regulated but still loaded: the cycle may repeat, keep counting
   assign ovl_run = !start_q && ovl_cnt_q != 32'h00000000;
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ovl_cnt_q <= 32'h00000000;
         opp_cnt_q <= 32'h00000000;
         opp_q <= 1'b0;
      end else if (opp_q) begin
         ovl_cnt_q <= 32'h00000000;
         if (opp_cnt_q >= OPP_OFF_CYC) begin
            opp_q <= 1'b0;
            opp_cnt_q <= 32'h00000000;
         end else begin
            opp_cnt_q <= opp_cnt_q + 32'h00000001;
         end
      end else if (ovl_keep || ovl_open) begin
         if (ovl_cnt_q >= OVL_CYC) begin
            opp_q <= 1'b1;
         end else begin
            ovl_cnt_q <= ovl_cnt_q + 32'h00000001;
         end
      end else if (ovl_clear) begin
         ovl_cnt_q <= 32'h00000000;
      end else if (ovl_run) begin
         ovl_cnt_q <= ovl_cnt_q + 32'h00000001;
      end
   end
   assign OVERPOWER_TRIP = opp_q;

   // Feedback sense failure: short debounce well inside response limit
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         SENSE_FAULT <= 1'b0;
         sense_cnt_q <= 16'h0000;
      end else if (!SENSE_FAULT) begin
         if (fb_q < line_q) begin
            if (sense_cnt_q >= `SENSE_DLY) begin
               SENSE_FAULT <= 1'b1;
               sense_cnt_q <= 16'h0000;
            end else begin
               sense_cnt_q <= sense_cnt_q + 16'h0001;
            end
         end else begin
            sense_cnt_q <= 16'h0000;
         end
      end else if (fb_q >= line_q && fb_q > peak_q) begin
         SENSE_FAULT <= 1'b0;
      end
   end

   assign inhibit = BROWNOUT | OVERVOLTAGE_TRIP | sev_hold |
                    opp_q | SENSE_FAULT | hot;
   assign SWITCH_DRIVE_OUTPUT = drive_q & ~inhibit;
endmodule // pfc_protection_supervisor

// file: hdl/pfc_defs.vh
// Constants for the protection supervisor
// Summary of operation
// - Digitized feedback current is compared with the 129 uA reference to form error.
// - Feedback loop is compensated digitally; no external network needed.
// - Valley pulse only after comparator high continuously for 200 ns.
// - A new cycle may start at a later valley, not always the first.
// - Brownout works on digitized line samples and tracks the rectified peak.
// - Line below low threshold for over 56 ms asserts brownout and stops drive.
// - Brownout exits after line above high threshold for at least 56 ms.
// - Low threshold 31.6 uA, high threshold 39.6 uA, giving hysteresis.
// - In brownout sit in standby, keep sampling, then return to normal.
// - Drive stops at once when feedback exceeds 105% of reference.
// - Overvoltage clears only below trip level minus hysteresis.
// - Current limit checked only while on and after blanking; ends on-time.
// - Severe clamp turns gate off and inhibits switching about 1.6 ms.
// - Overload drops output below startup level; startup until nominal reached.
// - Overload lasting over 112 ms causes 2.5 s shutdown, then restart.
// - Drive stops when measured output is below measured line.
// - Resume when feedback at least line and output above line peak.
// - Failed feedback sense stops drive within about 150 us.
// - Over-temperature shuts logic off; re-enabled after 9 C drop. Here THERMAL_HOT only inhibits the drive; hysteresis is left to the sensor.
// - Startup mode below 90% of nominal, normal again at 100%.
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
`define CLK_HZ 50000000
`define ADC_W 12
// Codes are 0.1 uA per LSB
`define REF_CODE 12'd1290
`define OVP_CODE 12'd1354
`define OVP_HYS_CODE 12'd26
`define START_CODE 12'd1161
`define LINE_LOW_CODE 12'd316
`define LINE_HIGH_CODE 12'd396
`define QUAL_NS 200
`define QUAL_CYC ((`QUAL_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define LEB_NS 300
`define LEB_CYC ((`LEB_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MS_CYC (`CLK_HZ / 1000)
`define BROWN_MS 56
`define SEVERE_US 1600
`define SEVERE_CYC (`SEVERE_US * (`CLK_HZ / 1000000))
`define OVL_MS 112
`define OPP_OFF_MS 2500
`define SENSE_US 150
`define SENSE_CYC (`SENSE_US * (`CLK_HZ / 1000000))
`define SENSE_DLY 16'd64
`define ERR_W 13
`endif

// file: hdl/pin_sync.v
// Three-flop pin synchroniser with agreement check
`timescale 1ns/1ps
module pin_sync (
   input wire clk,
   input wire rst_n,
   input wire pin,
   output reg level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end
endmodule // pin_sync

// file: bench/pfc_stage_model.sv
// Boost stage stand-in: aux ringing and shunt limit comparator
`timescale 1ns/1ps
module pfc_stage_model (
   input wire logic clk,
   input wire logic drive,
   input wire logic glitch,
   input wire logic [7:0] lim_at,
   output logic valley,
   output logic limit
);
   int ph = 0;
   int on = 0;
   always @(posedge clk) begin
      on <= drive ? on + 1 : 0;
      ph <= drive ? 0 : (ph + 1) % 20;
   end
   // Glitch mode keeps highs short of the qualify time
   assign valley = !drive && ph >= 2 && ph < (glitch ? 8 : 16);
   assign limit = lim_at != 0 && on >= lim_at;
endmodule // pfc_stage_model

// file: bench/pfc_protection_supervisor_chk.sv
// Port assertions for the protection supervisor
`timescale 1ns/1ps
module pfc_protection_supervisor_chk (
   input wire REF_CLK,
   input wire ARST_N,
   input wire [11:0] OUTPUT_FEEDBACK_INPUT,
   input wire SAMPLE_VALID,
   input wire VALLEY_DETECT_INPUT,
   input wire SWITCH_REQUEST,
   input wire SEVERE_CLAMP_TRIP,
   input wire THERMAL_HOT,
   input wire SWITCH_DRIVE_OUTPUT,
   input wire VALLEY_PULSE,
   input wire signed [12:0] REGULATION_ERROR,
   input wire BROWNOUT,
   input wire OVERVOLTAGE_TRIP,
   input wire OVERCURRENT_TRIP,
   input wire OVERPOWER_TRIP,
   input wire SENSE_FAULT,
   input wire STARTUP_MODE,
   input wire THERMAL_SHUTDOWN
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // Length of the last high run seen on the valley pin
   reg [7:0] run_q;
   reg [7:0] last_q;
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run_q <= 8'h00;
         last_q <= 8'h00;
      end else begin
         run_q <= VALLEY_DETECT_INPUT ? run_q + {7'h00, run_q != 8'hff} : 8'h00;
         if (!VALLEY_DETECT_INPUT && run_q != 8'h00)
            last_q <= run_q;
      end
   end
   inhibit_all_a: assert property ((BROWNOUT || OVERVOLTAGE_TRIP || OVERPOWER_TRIP ||
      SENSE_FAULT || THERMAL_SHUTDOWN) |-> !SWITCH_DRIVE_OUTPUT) else $error("drive on");
   ovp_set_a: assert property (SAMPLE_VALID && OUTPUT_FEEDBACK_INPUT > 12'h54a
      |=> OVERVOLTAGE_TRIP) else $error("ovp set");
   ovp_hold_a: assert property (OVERVOLTAGE_TRIP && SAMPLE_VALID && OUTPUT_FEEDBACK_INPUT
      >= 12'h530 |=> OVERVOLTAGE_TRIP) else $error("ovp hold");
   reg_error_a: assert property (SAMPLE_VALID |=> REGULATION_ERROR ==
      13'sh50a - $signed({1'b0, $past(OUTPUT_FEEDBACK_INPUT)})) else $error("error");
   valley_qual_a: assert property (VALLEY_PULSE |-> last_q >= 8'h0a ##1 !VALLEY_PULSE)
      else $error("valley");
   severe_hold_a: assert property ($rose(SEVERE_CLAMP_TRIP) |-> ##[2:6]
      (OVERCURRENT_TRIP && !SWITCH_DRIVE_OUTPUT)[*8]) else $error("severe");
   thermal_off_a: assert property ($rose(THERMAL_HOT) |-> ##[2:5]
      (THERMAL_SHUTDOWN && !SWITCH_DRIVE_OUTPUT)) else $error("thermal");
   drive_start_a: assert property ($rose(SWITCH_DRIVE_OUTPUT) |->
      $past(VALLEY_PULSE) && $past(SWITCH_REQUEST)) else $error("start");
   request_end_a: assert property (SWITCH_DRIVE_OUTPUT && !SWITCH_REQUEST
      |=> !SWITCH_DRIVE_OUTPUT) else $error("req end");
   startup_on_a: assert property (SAMPLE_VALID && OUTPUT_FEEDBACK_INPUT < 12'h489
      |=> STARTUP_MODE) else $error("startup");
endmodule // pfc_protection_supervisor_chk
bind pfc_protection_supervisor pfc_protection_supervisor_chk i_chk (.*);

// file: bench/testbench.sv
// Self-checking bench for the protection supervisor
`timescale 1ns/1ps
module testbench;
   logic clk = 0;
   logic rst_n = 0;
   logic sv = 0, req = 0, clamp = 0, hot = 0, gl = 1;
   logic [11:0] fb = 12'h50a, ln = 12'h0c8;
   logic [7:0] lim = 8'h00;
   wire drv, vp, bo, sb, overvoltage_trip, oc, op, sf, st, th, vd, cl;
   wire signed [12:0] err;
   int bad_count = 0, check_count = 0, cyc = 0, n, k;
   int tbl[8] = '{1160, 1290, 1355, 1354, 1328, 1327, 1161, 1289};
   bit ov_m = 0, st_m = 1;
   always #10 clk = ~clk;
   // Short counts keep the run brief
   pfc_protection_supervisor #(.BROWN_CYC(200), .OVL_CYC(300), .OPP_OFF_CYC(300),
      .SEVERE_CYC(50)) i_dut (.REF_CLK(clk), .ARST_N(rst_n), .OUTPUT_FEEDBACK_INPUT(fb),
      .LINE_SENSE_INPUT(ln), .SAMPLE_VALID(sv), .VALLEY_DETECT_INPUT(vd), .SWITCH_REQUEST(req),
      .CURRENT_LIMIT_TRIP(cl), .SEVERE_CLAMP_TRIP(clamp), .THERMAL_HOT(hot),
      .SWITCH_DRIVE_OUTPUT(drv), .VALLEY_PULSE(vp), .REGULATION_ERROR(err), .BROWNOUT(bo),
      .STANDBY(sb), .OVERVOLTAGE_TRIP(overvoltage_trip), .OVERCURRENT_TRIP(oc), .OVERPOWER_TRIP(op),
      .SENSE_FAULT(sf), .STARTUP_MODE(st), .THERMAL_SHUTDOWN(th));
   pfc_stage_model i_stage (.clk(clk), .drive(drv), .glitch(gl), .lim_at(lim), .valley(vd),
      .limit(cl));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic w(input int c);
      repeat (c) @(posedge clk);
   endtask
   // One sample, checked against the model; ends on a rising edge
   task automatic smp(input int f, input int l);
      fb <= f[11:0];
      ln <= l[11:0];
      sv <= 1'b1;
      w(1);
      sv <= 1'b0;
      w(1);
      #1;
      if (f > 1354)
         ov_m = 1;
      else if (f < 1328)
         ov_m = 0;
      if (f < 1161)
         st_m = 1;
      if (f >= 1290)
         st_m = 0;
      cmp({3'h0, err}, {3'h0, 13'(1290 - f)});
      cmp(overvoltage_trip, ov_m);
      w(1);
   endtask
   // Remaining length of the current on-time, else of the next one, bounded
   task automatic onlen(output int m);
      m = 0;
      for (int i = 0; i < 300 && !drv; i++) begin
         w(1);
         #1;
      end
      while (drv && m < 300) begin
         w(1);
         #1;
         m++;
      end
   endtask
   initial begin
      void'($urandom(32'h94fa));
      w(10);
      rst_n <= 1'b1;
      w(3);
      for (k = 0; k < 220; k++) begin
         smp(1290, 200);
         if (k == 50)
            cmp(bo, 0);
      end
      cmp({bo, sb, drv}, 3'b110);
      for (k = 0; k < 220; k++) begin
         smp(1290, 500);
         if (k == 50)
            cmp(bo, 1);
      end
      cmp({bo, sb}, 2'b00);
      for (k = 0; k < 40; k++) begin
         n = k < 8 ? tbl[k] : 1162 + $urandom % 200;
         smp(n, 500);
         cmp(st, st_m);
      end
      smp(1290, 500);
      n = 0;
      for (k = 0; k < 200; k++) begin
         w(1);
         #1;
         n += vp;
      end
      cmp(n, 0);
      w(1);
      gl <= 1'b0;
      req <= 1'b1;
      n = 0;
      for (k = 0; k < 200; k++) begin
         w(1);
         #1;
         n += vp;
      end
      cmp({n != 0, drv}, 2'b11);
      w(1);
      lim <= 8'h05;
      onlen(n);
      onlen(n);
      cmp({n >= 15 && n <= 18, oc}, 2'b11);
      w(1);
      lim <= 8'h28;
      onlen(n);
      onlen(n);
      cmp(n >= 42 && n <= 47, 1);
      w(1);
      lim <= 8'h00;
      clamp <= 1'b1;
      w(5);
      clamp <= 1'b0;
      w(20);
      #1;
      cmp({oc, drv}, 2'b10);
      w(60);
      #1;
      cmp(oc, 0);
      w(1);
      hot <= 1'b1;
      w(10);
      #1;
      cmp({th, drv}, 2'b10);
      w(1);
      hot <= 1'b0;
      for (k = 0; k < 40; k++)
         smp(300, 500);
      cmp({th, sf, drv}, 3'b010);
      req <= 1'b0;
      for (k = 0; k < 3; k++)
         smp(450, 400);
      cmp(sf, 1);
      for (k = 0; k < 3; k++)
         smp(1290, 500);
      cmp(sf, 0);
      req <= 1'b1;
      for (k = 0; k < 111; k++) begin
         smp(1100, 500);
         if (k == 60)
            cmp(op, 0);
      end
      cmp({op, drv}, 2'b10);
      req <= 1'b0;
      for (k = 0; k < 150; k++) begin
         smp(1290, 500);
         if (k == 30)
            cmp(op, 1);
      end
      cmp(op, 0);
      tally_and_finish();
   end
endmodule // testbench
